// [core/dfs_ctl.sv]
// Purpose: file control unit end, Avalon-MM slave for software
// Assumes: field word written by software in place of a storage fetch
// Notes:   waitrequest low on the cycle after a request is seen
`timescale 1ns/1ps
`default_nettype none
module dfs_ctl (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // link to the file
  dfs_link_if.ctl          link,
  // controller status
  output logic             attention
);
  import dfs_pkg::*;
  logic [15:0] control_field_pointer;
  logic [31:0] field;
  logic [4:0]  ctrl;
  logic        ack;
  logic [7:0]  hs, cnt, cyl, flg;
  logic        field_bad;

  assign hs  = field[FLD_HS_LSB +: 8];
  assign cnt = field[FLD_COUNT_LSB +: 8];
  assign cyl = field[FLD_CYL_LSB +: 8];
  assign flg = field[FLD_FLAG_LSB +: 8];
  // sector field 0..23, low two bits zero for data ops
  assign field_bad = ((hs & HS_LOW_BITS) != 8'h00)
    || ((hs[6:2]) > HS_SECT_MAX[4:0]) || (cyl > CYL_MAX);

  // waitrequest is a flop: one wait state, then low for one cycle
  always_ff @(posedge mclk) begin
    if (rst) avs_waitrequest <= 1'b1;
    else avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end
  assign ack = !avs_waitrequest;

  always_ff @(posedge mclk) begin
    if (rst) begin
      control_field_pointer <= PTR_RESET;
      field <= 32'h0000_0000;
      ctrl <= 5'h00;
    end else if (avs_write && ack) begin
      unique case (avs_address)
        REG_CTRL:    ctrl <= avs_writedata[4:0];
        REG_POINTER: control_field_pointer <= avs_writedata[15:0];
        REG_FIELD:   field <= avs_writedata;
        default: ;
      endcase
    end else begin
      ctrl[CTRL_START] <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack) begin
      unique case (avs_address)
        REG_CTRL:    avs_readdata <= {27'h0, ctrl};
        REG_STATUS:  avs_readdata <= {16'h0, link.sense_byte2, flg[1:0],
          field_bad, attention, link.access_overrun, link.equip_check,
          link.file_ready, link.data_unsafe};
        REG_POINTER: avs_readdata <= {16'h0, control_field_pointer};
        REG_FIELD:   avs_readdata <= field;
        default:     avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // drive the file; nothing runs while unsafe
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.read_sel <= 1'b0;
      link.write_sel <= 1'b0;
      link.erase_sel <= 1'b0;
      link.head_sel <= 8'h00;
      link.seek_go <= 1'b0;
      link.seek_fwd <= 1'b0;
      link.seek_count <= 8'h00;
      attention <= 1'b0;
    end else begin
      link.read_sel  <= ctrl[CTRL_READ] && !link.data_unsafe && !field_bad;
      link.write_sel <= ctrl[CTRL_WRITE] && !link.data_unsafe
        && !field_bad;
      link.erase_sel <= ctrl[CTRL_ERASE] && !link.data_unsafe;
      link.head_sel  <= hs[7] ? 8'h02 : 8'h01;
      // seek takes only head/sector and count bytes
      link.seek_go <= ctrl[CTRL_START] && !link.data_unsafe;
      link.seek_fwd <= (hs & HS_SEEK_FWD) != 8'h00;
      link.seek_count <= cnt;
      if (ctrl[CTRL_START] && !link.file_ready) attention <= 1'b1;
      else if (avs_write && ack && avs_address == REG_STATUS)
        attention <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [core/dfs_file.sv]
// Purpose: disk file safety latches, ready and access overrun
// Assumes: sensor pins asynchronous, three-flop synchronised
// Notes:   only reset or a stop of the file clears the unsafe latches
`timescale 1ns/1ps
`default_nettype none
module dfs_file (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // link to the controller
  dfs_link_if.file  link,
  // file sensors (asynchronous pins)
  input  wire logic running,
  input  wire logic interlock_ok,
  input  wire logic [6:0] speed_pct,
  input  wire logic heads_loaded,
  input  wire logic ac_ok,
  input  wire logic write_transitions,
  input  wire logic write_current,
  input  wire logic erase_current,
  input  wire logic carriage_moving,
  input  wire logic inner_limit,
  input  wire logic monitor_en,
  // drive outputs
  output logic      read_gate,
  output logic      write_gate,
  output logic      access_fwd_drive
);
  import dfs_pkg::*;
  // bit positions in the pin vector that is synchronised as a whole
  localparam int NS          = 10;
  localparam int P_RUNNING   = 9;
  localparam int P_INTERLOCK = 8;
  localparam int P_HEADS     = 7;
  localparam int P_AC        = 6;
  localparam int P_WR_TRANS  = 5;
  localparam int P_WR_CUR    = 4;
  localparam int P_ER_CUR    = 3;
  localparam int P_CARRIAGE  = 2;
  localparam int P_LIMIT     = 1;
  localparam int P_MONITOR   = 0;

  logic [NS-1:0] pin_raw;
  logic [NS-1:0] s1;
  logic [NS-1:0] s2;
  logic [NS-1:0] s3;
  logic [NS-1:0] sq;
  logic [6:0]    spd1;
  logic [6:0]    spd2;
  logic [6:0]    spd3;
  logic [6:0]    spd;
  logic          rd;
  logic          wr;
  logic          er;
  logic          multi;
  logic          write_fault;
  logic          erase_fault;
  logic          select_fault;
  logic          write_unsafe;
  logic          erase_unsafe;
  logic          select_unsafe;
  logic          unsafe;
  logic          was_running;
  logic          ready_ok;

  assign pin_raw = {running, interlock_ok, heads_loaded, ac_ok,
                    write_transitions, write_current, erase_current,
                    carriage_moving, inner_limit, monitor_en};

  // three flops against metastability; a level counts only once the
  // second and third agree, so a one-cycle glitch never reaches logic
  always_ff @(posedge mclk) begin
    s1 <= pin_raw;
    s2 <= s1;
    s3 <= s2;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sq <= '0;
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (s2[i] == s3[i]) begin
          sq[i] <= s3[i];
        end
      end
    end
  end

  // speed is taken as one word, only when all its bits agree
  always_ff @(posedge mclk) begin
    spd1 <= speed_pct;
    spd2 <= spd1;
    spd3 <= spd2;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      spd <= 7'h00;
    end else if (spd2 == spd3) begin
      spd <= spd3;
    end
  end

  // controller selections share this clock, so no synchroniser
  assign rd    = link.read_sel;
  assign wr    = link.write_sel;
  assign er    = link.erase_sel;
  assign multi = (link.head_sel & (link.head_sel - 8'h01)) != 8'h00;

  // fault terms are looked at on every cycle the file runs
  assign write_fault  = (wr && !sq[P_WR_TRANS]) || (wr && multi)
                        || (!wr && sq[P_WR_CUR]);
  assign erase_fault  = (wr && !sq[P_ER_CUR])
                        || (!wr && sq[P_ER_CUR]);
  assign select_fault = (rd && (wr || er))
                        || (sq[P_CARRIAGE] && (wr || er));

  // ready waits one more sample after the file comes up again
  always_ff @(posedge mclk) begin
    if (rst) begin
      was_running <= 1'b0;
    end else begin
      was_running <= sq[P_RUNNING];
    end
  end

  // stopping the file or reset is the only clear; it beats a set so that a
  // restart always begins from a clean state
  always_ff @(posedge mclk) begin
    if (rst || !sq[P_RUNNING]) begin
      write_unsafe <= 1'b0;
    end else if (write_fault) begin
      write_unsafe <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !sq[P_RUNNING]) begin
      erase_unsafe <= 1'b0;
    end else if (erase_fault) begin
      erase_unsafe <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || !sq[P_RUNNING]) begin
      select_unsafe <= 1'b0;
    end else if (select_fault) begin
      select_unsafe <= 1'b1;
    end
  end

  assign unsafe   = write_unsafe | erase_unsafe | select_unsafe;
  assign ready_ok = sq[P_RUNNING] && was_running && sq[P_INTERLOCK]
                    && sq[P_HEADS] && sq[P_AC] && (spd > SPEED_MIN);

  // unsafe report and equipment check follow the latches together
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.data_unsafe <= 1'b0;
      link.equip_check <= 1'b0;
    end else begin
      link.data_unsafe <= unsafe;
      link.equip_check <= unsafe;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      link.file_ready <= 1'b0;
    end else begin
      link.file_ready <= ready_ok && !unsafe;
    end
  end

  // gates drop with the latch, so no transfer slips past a fault
  always_ff @(posedge mclk) begin
    if (rst) begin
      read_gate  <= 1'b0;
      write_gate <= 1'b0;
    end else begin
      read_gate  <= rd && !unsafe && !er && !wr;
      write_gate <= wr && !unsafe;
    end
  end

  // forward drive is a pulse per seek start; the limit vetoes it
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.access_overrun <= 1'b0;
      access_fwd_drive    <= 1'b0;
    end else begin
      link.access_overrun <= sq[P_LIMIT];
      access_fwd_drive    <= link.seek_go && link.seek_fwd
                             && !sq[P_LIMIT];
    end
  end

  // latches are readable only while the monitor jumper is fitted
  always_ff @(posedge mclk) begin
    if (rst) begin
      link.sense_byte2 <= 8'h00;
    end else begin
      link.sense_byte2 <= sq[P_MONITOR] ? {1'b0, write_unsafe,
        select_unsafe, erase_unsafe, 4'h0} : 8'h00;
    end
  end
endmodule
`default_nettype wire

// [core/dfs_link_if.sv]
// Purpose: wires between disk file and file control unit
// Assumes: single clock mclk
// Notes:   one modport per party
`timescale 1ns/1ps
`default_nettype none
interface dfs_link_if;
  logic data_unsafe;
  logic file_ready;
  logic equip_check;
  logic access_overrun;
  logic [7:0] sense_byte2;
  logic read_sel;
  logic write_sel;
  logic erase_sel;
  logic [7:0] head_sel;
  logic seek_go;
  logic seek_fwd;
  logic [7:0] seek_count;
  modport file (output data_unsafe, file_ready, equip_check,
    access_overrun, sense_byte2,
    input read_sel, write_sel, erase_sel, head_sel, seek_go, seek_fwd,
    seek_count);
  modport ctl (input data_unsafe, file_ready, equip_check,
    access_overrun, sense_byte2,
    output read_sel, write_sel, erase_sel, head_sel, seek_go, seek_fwd,
    seek_count);
endinterface
`default_nettype wire

// [core/dfs_pkg.sv]
// Purpose: shared constants for the disk file safety link
// Assumes: one clock, synchronous active-high reset
// Notes:   control field byte layout and register offsets
package dfs_pkg;
  // controller register map, word offsets (byte address)
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_POINTER = 4'h8;
  localparam logic [3:0] REG_FIELD   = 4'hC;
  // control bits in REG_CTRL
  localparam int CTRL_START   = 0;
  localparam int CTRL_MONITOR = 1;
  localparam int CTRL_READ    = 2;
  localparam int CTRL_WRITE   = 3;
  localparam int CTRL_ERASE   = 4;
  // control field byte positions in the 32-bit field word
  localparam int FLD_FLAG_LSB  = 24;
  localparam int FLD_CYL_LSB   = 16;
  localparam int FLD_HS_LSB    = 8;
  localparam int FLD_COUNT_LSB = 0;
  localparam logic [7:0] CYL_MAX      = 8'hCB;
  localparam logic [7:0] HS_LOWER     = 8'h80;
  localparam logic [7:0] HS_SEEK_FWD  = 8'h01;
  localparam logic [7:0] HS_LOW_BITS  = 8'h03;
  localparam logic [7:0] HS_SECT_MAX  = 8'h17;
  // sense byte 2 bit positions, bit 7 is msb as in the [7:0] vector
  localparam int SNS_WRITE  = 6;
  localparam int SNS_SELECT = 5;
  localparam int SNS_ERASE  = 4;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [6:0]  SPEED_MIN = 7'h41;
endpackage

// [tb/dfs_link_sva.sv]
// Purpose: link checker for the disk file safety ends
// Assumes: one clock, rst synchronous active high
// Notes:   sensor pins unseen here, gates judged by the bench
`timescale 1ns/1ps
`default_nettype none
module dfs_link_sva
  import dfs_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // file side
  input wire logic       data_unsafe,
  input wire logic       file_ready,
  input wire logic       equip_check,
  input wire logic [7:0] sense_byte2,
  // controller side
  input wire logic       read_sel,
  input wire logic       write_sel,
  input wire logic       erase_sel,
  input wire logic [7:0] head_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence unsafe_seen;
    data_unsafe && equip_check && !file_ready;
  endsequence
  // sync depth plus latch plus output flop
  sequence latch_late;
    ##[1:6] unsafe_seen;
  endsequence
  ready_drop_a: assert property (
    data_unsafe |-> !file_ready) else $error("ready while unsafe");
  equip_set_a: assert property (
    data_unsafe |-> equip_check) else $error("no equipment check");
  unsafe_hold_a: assert property (
    $fell(data_unsafe) |-> !file_ready) else $error("unsafe left early");
  ready_gap_a: assert property (
    $rose(file_ready) |-> !$past(data_unsafe)) else $error("ready rose");
  read_write_a: assert property (
    read_sel && write_sel |-> latch_late) else $error("no select unsafe");
  read_erase_a: assert property (
    read_sel && erase_sel |-> latch_late) else $error("no select unsafe");
  multi_head_a: assert property (
    write_sel && ($countones(head_sel) > 1) |-> latch_late)
    else $error("no write unsafe");
  sense_show_a: assert property (
    (|sense_byte2[SNS_WRITE:SNS_ERASE]) |-> ##[0:1] data_unsafe)
    else $error("sense without unsafe");
endmodule
`default_nettype wire

// [tb/disk_file_safety_control_test.sv]
// Purpose: bench for both ends of the disk file safety link
// Assumes: 50 MHz mclk, rst held 10 cycles
// Notes:   fixed waits cover the pin sync depth given by the designer
`timescale 1ns/1ps
`default_nettype none
module disk_file_safety_control_test;
  import dfs_pkg::*;
  logic        mclk, rst, running, interlock_ok, heads_loaded, ac_ok;
  logic        write_transitions, write_current, erase_current;
  logic        carriage_moving, inner_limit, monitor_en, avs_read;
  logic        avs_write, avs_waitrequest, attention, read_gate;
  logic        write_gate, access_fwd_drive;
  logic [6:0]  speed_pct;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int          error_cnt, tests_run, cyc, fwd_cnt;
  dfs_link_if link ();
  dfs_file dfs_file_i (.*);
  dfs_ctl  dfs_ctl_i (.*);
  dfs_link_sva dfs_link_sva_i (.mclk(mclk), .rst(rst),
    .data_unsafe(link.data_unsafe), .file_ready(link.file_ready),
    .equip_check(link.equip_check), .sense_byte2(link.sense_byte2),
    .read_sel(link.read_sel), .write_sel(link.write_sel),
    .erase_sel(link.erase_sel), .head_sel(link.head_sel));
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      summarize();
    end
  end
  // forward drive stands one cycle, so count it as it happens
  always @(posedge mclk) begin
    if (access_fwd_drive === 1'b1) fwd_cnt++;
  end
  task summarize;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // request held until an edge samples waitrequest low; data taken there
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task settle;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
  endtask
  task restart;
    @(posedge mclk);
    running <= 0;
    settle;
    @(posedge mclk);
    running <= 1;
    settle;
  endtask
  task trip(input logic [31:0] c, input logic [2:0] p, input int b);
    bus(1, REG_CTRL, c);
    @(posedge mclk);
    {carriage_moving, write_current, erase_current} <= p;
    settle;
    chk(link.data_unsafe, 1);
    chk(link.file_ready, 0);
    chk(link.equip_check, 1);
    chk(link.sense_byte2[b], 1);
    chk({read_gate, write_gate}, 0);
    chk({link.read_sel, link.write_sel, link.erase_sel}, 0);
    @(posedge mclk);
    monitor_en <= 0;
    settle;
    chk(link.sense_byte2, 0);
    @(posedge mclk);
    monitor_en <= 1;
    bus(1, REG_CTRL, 0);
    @(posedge mclk);
    {carriage_moving, write_current, erase_current} <= 3'h0;
    settle;
    bus(0, REG_STATUS, 0);
    chk(rd[0], 1);
    restart;
    chk({link.data_unsafe, link.file_ready}, 1);
  endtask
  task t_regs;
    bus(0, REG_POINTER, 0);
    chk(rd, {16'h0, PTR_RESET});
    bus(1, REG_POINTER, 32'h0000_1A2B);
    bus(0, REG_POINTER, 0);
    chk(rd, 32'h0000_1A2B);
    bus(0, 4'h2, 0);
    chk(rd, 0);
    bus(1, REG_FIELD, 32'h00CB_5C00);
    bus(0, REG_STATUS, 0);
    chk(rd[5], 0);
    bus(1, REG_FIELD, 32'h00CC_DC00);
    bus(0, REG_STATUS, 0);
    chk(rd[5], 1);
    bus(1, REG_FIELD, 32'h0000_6000);
    bus(0, REG_STATUS, 0);
    chk(rd[5], 1);
    bus(1, REG_FIELD, 32'h0300_0000);
    bus(0, REG_STATUS, 0);
    chk(rd[7:5], 3'h6);
    bus(1, REG_FIELD, 0);
    bus(0, REG_STATUS, 0);
    chk(rd[1:0], 2'h2);
  endtask
  task t_unsafe;
    bus(1, REG_CTRL, 32'h1 << CTRL_READ);
    settle;
    chk(read_gate, 1);
    bus(1, REG_CTRL, 0);
    trip(0, 3'h1, SNS_ERASE);
    trip(0, 3'h2, SNS_WRITE);
    trip(32'h1 << CTRL_WRITE, 3'h0, SNS_WRITE);
    trip(32'h1 << CTRL_WRITE, 3'h0, SNS_ERASE);
    trip(32'h1 << CTRL_ERASE, 3'h4, SNS_SELECT);
    trip(32'h1 << CTRL_READ | 32'h1 << CTRL_ERASE, 3'h0,
      SNS_SELECT);
    trip(32'h1 << CTRL_READ | 32'h1 << CTRL_WRITE, 3'h0,
      SNS_SELECT);
  endtask
  task t_ready;
    @(posedge mclk);
    speed_pct <= SPEED_MIN;
    settle;
    chk(link.file_ready, 0);
    bus(1, REG_CTRL, 32'h1 << CTRL_START);
    bus(0, REG_STATUS, 0);
    chk(rd[4], 1);
    bus(1, REG_STATUS, 0);
    bus(0, REG_STATUS, 0);
    chk(rd[4], 0);
    @(posedge mclk);
    speed_pct <= SPEED_MIN + 7'h1;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      {interlock_ok, heads_loaded, ac_ok} <= ~(3'h1 << i);
      settle;
      chk(link.file_ready, 0);
    end
    @(posedge mclk);
    {interlock_ok, heads_loaded, ac_ok} <= 3'h7;
    settle;
    chk(link.file_ready, 1);
  endtask
  task t_limit;
    int base;
    bus(1, REG_FIELD, 32'h03CC_8102);
    settle;
    chk(link.head_sel, 8'h02);
    chk(link.seek_fwd, 1);
    chk(link.seek_count, 8'h02);
    base = fwd_cnt;
    bus(1, REG_CTRL, 32'h1 << CTRL_START);
    settle;
    chk(fwd_cnt - base, 1);
    @(posedge mclk);
    inner_limit <= 1;
    settle;
    chk(link.access_overrun, 1);
    base = fwd_cnt;
    bus(1, REG_CTRL, 32'h1 << CTRL_START);
    settle;
    chk(fwd_cnt - base, 0);
    @(posedge mclk);
    inner_limit <= 0;
    bus(1, REG_FIELD, 0);
  endtask
  initial begin
    rst = 1;
    {running, interlock_ok, heads_loaded, ac_ok, monitor_en} = 5'h1F;
    {write_transitions, write_current, erase_current} = 3'h0;
    {carriage_moving, inner_limit, avs_read, avs_write} = 4'h0;
    speed_pct = 7'h64;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    repeat (10) @(posedge mclk);
    rst <= 0;
    settle;
    t_regs;
    t_unsafe;
    t_ready;
    t_limit;
    summarize;
  end
endmodule
`default_nettype wire
